// [src/bct_defines.svh]
// register offsets, field positions, reset values and timing counts of the timekeeper
`ifndef BCT_DEFINES_SVH
`define BCT_DEFINES_SVH

// register offsets on the plain port
`define BCT_OFF_CONTROL    4'h0
`define BCT_OFF_WIN_HIGH   4'h1
`define BCT_OFF_WIN_LOW    4'h2
`define BCT_OFF_ALM_CTRL   4'h3
`define BCT_OFF_ALM_HIGH   4'h4
`define BCT_OFF_ALM_LOW    4'h5
`define BCT_OFF_PIN_SEL    4'h6

// control register field positions
`define BCT_CTL_ENABLE_BIT 7
`define BCT_CTL_WREN_BIT   5
`define BCT_CTL_HALF_BIT   3
`define BCT_CTL_PTR_HI     1
`define BCT_CTL_PTR_LO     0

// pin select field position
`define BCT_PSEL_HI        2
`define BCT_PSEL_LO        1

// reset values
`define BCT_RST_CONTROL    8'h00
`define BCT_RST_PTR        2'h0
`define BCT_RST_PSEL       2'h0

// counter clock rate and half second in source cycles
`define BCT_XTAL_HZ        32768
`define BCT_HALF_TICKS     16384

`endif

// [src/bct_pkg.sv]
// types shared by the timekeeper
package bct_pkg;
    typedef logic [7:0] bct_byte_t;
    typedef logic [1:0] bct_ptr_t;
    typedef enum logic [1:0] {
        BCT_PSEL_ALARM  = 2'h0,
        BCT_PSEL_SECOND = 2'h1,
        BCT_PSEL_SOURCE = 2'h2,
        BCT_PSEL_RSVD   = 2'h3
    } bct_psel_t;
endpackage

// [src/bct_timekeeper.sv]
// BCD time-of-day and calendar counter with pointer-indexed value windows
`timescale 1ns/1ps
`include "bct_defines.svh"

module bct_timekeeper
    import bct_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic       writeUnlock,
    input  wire logic       counterClockSelect,
    input  wire logic       crystalClockPin,
    input  wire logic       internalOscPin,
    output logic      [7:0] regRdData,
    output logic            crystalOscEnable,
    output logic            pinOut
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // increment one BCD pair with wrap: returns {carry, next value}
    // the ones digit rolls at ten, so a bad digit written by software
    // still counts on instead of locking the chain; the wrap compare
    // looks at the whole pair so each field keeps its own end value
    function automatic logic [8:0] bcdStep(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
        logic [7:0] r;
        r = v;
        if (v == last) begin
            return {1'b1, first};
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return {1'b0, r};
    endfunction

    // last day of a month in BCD
    // leap test on BCD digits: even tens with ones 0/4/8, odd tens with 2/6
    // year 00 counts as leap, the whole range needs no century rule
    function automatic logic [7:0] monthLast(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = (yr[4] == 1'b0) ? (yr[1:0] == 2'b00) : (yr[1:0] == 2'b10);
        case (mon)
            8'h02:   return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // source clock select and synchronisers

    // both source pins are free running, so each gets its own pair of flops
    // and only the second flop of each pair feeds the select mux
    logic [1:0] xtalSync;
    logic [1:0] intSync;
    logic       srcClk;
    logic       srcPrev;
    logic       srcRise;

    // two stages before any logic, selected level delayed for edge detection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtalSync <= 2'h0;
            intSync  <= 2'h0;
            srcPrev  <= 1'b0;
        end else begin
            xtalSync <= {xtalSync[0], crystalClockPin};
            intSync  <= {intSync[0], internalOscPin};
            srcPrev  <= srcClk;
        end
    end

    assign srcClk  = counterClockSelect ? intSync[1] : xtalSync[1];
    assign srcRise = srcClk & ~srcPrev;

    ////////////////////////////////////////////////////////////////////
    // state
    // value fields are kept as full bytes with unused bits forced to zero
    // on every write, so reads need no masking and no write leaves a set bit
    // above the field; a counter stepped on from an out-of-range tens digit can still carry into one

    logic            enable, next_enable;
    logic            wren, next_wren;
    bct_ptr_t        ptr, next_ptr;
    bct_ptr_t        almPtr, next_almPtr;
    bct_psel_t       psel, next_psel;
    logic [13:0]     prescale, next_prescale;
    logic            halfSec, next_halfSec;
    bct_byte_t       sec, next_sec, min, next_min, hour, next_hour;
    bct_byte_t       weekday_digit, next_weekday_digit, day, next_day, mon, next_mon, year, next_year;
    bct_byte_t       aSec, next_aSec, aMin, next_aMin, aHour, next_aHour;
    bct_byte_t       aWday, next_aWday, aDay, next_aDay, aMon, next_aMon;
    bct_byte_t       rdData, next_rdData;
    logic            pinReg, next_pinReg;

    // window writes qualified by write-enable; a locked write is dropped
    // whole, including the pointer step it would otherwise cause
    logic wrHigh, wrLow, aWrHigh, aWrLow;
    assign wrHigh  = regWrite && regAddr == `BCT_OFF_WIN_HIGH && wren;
    assign wrLow   = regWrite && regAddr == `BCT_OFF_WIN_LOW  && wren;
    assign aWrHigh = regWrite && regAddr == `BCT_OFF_ALM_HIGH && wren;
    assign aWrLow  = regWrite && regAddr == `BCT_OFF_ALM_LOW  && wren;

    ////////////////////////////////////////////////////////////////////
    // next-state: control, counters, window writes

    always_comb begin
        logic [8:0] s;
        logic       carry;
        s             = 9'h0;
        carry         = 1'b0;
        next_enable   = enable;
        next_wren     = wren;
        next_ptr      = ptr;
        next_almPtr   = almPtr;
        next_psel     = psel;
        next_prescale = prescale;
        next_halfSec  = halfSec;
        next_sec = sec; next_min = min; next_hour = hour;
        next_weekday_digit = weekday_digit; next_day = day; next_mon = mon; next_year = year;
        next_aSec = aSec; next_aMin = aMin; next_aHour = aHour;
        next_aWday = aWday; next_aDay = aDay; next_aMon = aMon;

        // prescaler: two halves of 16384 source edges each
        // the half-second bit is the top of the prescaler, so a second
        // ends on the falling half; disabling freezes the prescaler in place
        // instead of clearing it
        if (enable && srcRise) begin
            if (prescale == 14'(`BCT_HALF_TICKS - 1)) begin
                next_prescale = 14'h0;
                next_halfSec  = ~halfSec;
                if (halfSec) begin
                    carry         = 1'b1;
                end
            end else begin
                next_prescale = prescale + 14'h1;
            end
        end

        // time and calendar carry chain
        // one step per second, each field only moves when all lower ones wrap
        // weekday steps beside the day but never carries onward
        // the month end is looked up from the month and year before the step
        if (carry) begin
            s = bcdStep(sec, 8'h59, 8'h00); next_sec = s[7:0];
            if (s[8]) begin
                s = bcdStep(min, 8'h59, 8'h00); next_min = s[7:0];
                if (s[8]) begin
                    s = bcdStep(hour, 8'h23, 8'h00); next_hour = s[7:0];
                    if (s[8]) begin
                        next_weekday_digit = (weekday_digit == 8'h06) ? 8'h00 : weekday_digit + 8'h01;
                        s = bcdStep(day, monthLast(mon, year), 8'h01); next_day = s[7:0];
                        if (s[8]) begin
                            s = bcdStep(mon, 8'h12, 8'h01); next_mon = s[7:0];
                            if (s[8]) begin
                                s = bcdStep(year, 8'h99, 8'h00); next_year = s[7:0];
                            end
                        end
                    end
                end
            end
        end

        // control register writes
        // write-enable can only be raised with the unlock strobe, but can
        // always be dropped; the enable bit obeys the old write-enable,
        // so raising both in one write keeps the module stopped
        if (regWrite && regAddr == `BCT_OFF_CONTROL) begin
            next_wren = writeUnlock ? regWrData[`BCT_CTL_WREN_BIT] : (wren & regWrData[`BCT_CTL_WREN_BIT]);
            if (wren) begin
                next_enable = regWrData[`BCT_CTL_ENABLE_BIT];
            end
            next_ptr = regWrData[`BCT_CTL_PTR_HI:`BCT_CTL_PTR_LO];
        end
        if (regWrite && regAddr == `BCT_OFF_ALM_CTRL) begin
            next_almPtr = regWrData[1:0];
        end
        if (regWrite && regAddr == `BCT_OFF_PIN_SEL) begin
            next_psel = bct_psel_t'(regWrData[`BCT_PSEL_HI:`BCT_PSEL_LO]);
        end

        // value window writes, masked to field widths
        // these come after the carry chain so a write wins over a tick
        // landing in the same cycle
        if (wrHigh) begin
            case (ptr)
                2'h0:    next_min  = {1'b0, regWrData[6:0]};
                2'h1:    next_weekday_digit = {5'h0, regWrData[2:0]};
                2'h2:    next_mon  = {3'h0, regWrData[4:0]};
                default: next_mon  = next_mon;
            endcase
        end
        if (wrLow) begin
            case (ptr)
                2'h0: begin
                    next_sec      = {1'b0, regWrData[6:0]};
                    next_prescale = 14'h0;
                    next_halfSec  = 1'b0;
                end
                2'h1:    next_hour = {2'h0, regWrData[5:0]};
                2'h2:    next_day  = {2'h0, regWrData[5:0]};
                default: next_year = regWrData;
            endcase
        end
        if (wrHigh && ptr == 2'h0) begin
            next_prescale = 14'h0;
            next_halfSec  = 1'b0;
        end

        // alarm window writes
        // same layouts as the time fields; the matcher itself lives elsewhere
        // so these are plain storage
        if (aWrHigh) begin
            case (almPtr)
                2'h0:    next_aMin  = {1'b0, regWrData[6:0]};
                2'h1:    next_aWday = {5'h0, regWrData[2:0]};
                2'h2:    next_aMon  = {3'h0, regWrData[4:0]};
                default: next_aMon  = next_aMon;
            endcase
        end
        if (aWrLow) begin
            case (almPtr)
                2'h0:    next_aSec  = {1'b0, regWrData[6:0]};
                2'h1:    next_aHour = {2'h0, regWrData[5:0]};
                2'h2:    next_aDay  = {2'h0, regWrData[5:0]};
                default: next_aDay  = next_aDay;
            endcase
        end

        // high window access walks the pointer down to zero
        // a read always steps, a write only when it is accepted,
        // so software can fill a whole set with repeated low/high pairs
        if ((regRead || (regWrite && wren)) && regAddr == `BCT_OFF_WIN_HIGH && ptr != 2'h0) begin
            next_ptr = ptr - 2'h1;
        end
        if ((regRead || (regWrite && wren)) && regAddr == `BCT_OFF_ALM_HIGH && almPtr != 2'h0) begin
            next_almPtr = almPtr - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data and pin output
    // read data is registered for one cycle and returns to zero after,
    // so a stale value can never be mistaken for a new read
    // reads have no side effect here except the pointer step above

    always_comb begin
        next_rdData = 8'h00;
        if (regRead) begin
            if (regAddr == `BCT_OFF_CONTROL) begin
                next_rdData = {enable, 1'b0, wren, 1'b0, halfSec, 1'b0, ptr};
            end else if (regAddr == `BCT_OFF_WIN_HIGH) begin
                case (ptr)
                    2'h0:    next_rdData = min;
                    2'h1:    next_rdData = weekday_digit;
                    2'h2:    next_rdData = mon;
                    default: next_rdData = 8'h00;
                endcase
            end else if (regAddr == `BCT_OFF_WIN_LOW) begin
                case (ptr)
                    2'h0:    next_rdData = sec;
                    2'h1:    next_rdData = hour;
                    2'h2:    next_rdData = day;
                    default: next_rdData = year;
                endcase
            end else if (regAddr == `BCT_OFF_ALM_CTRL) begin
                next_rdData = {6'h0, almPtr};
            end else if (regAddr == `BCT_OFF_ALM_HIGH) begin
                case (almPtr)
                    2'h0:    next_rdData = aMin;
                    2'h1:    next_rdData = aWday;
                    2'h2:    next_rdData = aMon;
                    default: next_rdData = 8'h00;
                endcase
            end else if (regAddr == `BCT_OFF_ALM_LOW) begin
                case (almPtr)
                    2'h0:    next_rdData = aSec;
                    2'h1:    next_rdData = aHour;
                    2'h2:    next_rdData = aDay;
                    default: next_rdData = 8'h00;
                endcase
            end else if (regAddr == `BCT_OFF_PIN_SEL) begin
                next_rdData = {5'h0, psel, 1'b0};
            end else begin
                next_rdData = 8'h00; // unmapped
            end
        end

        // pin mux: alarm path lives elsewhere, so it idles low
        // the source mode shows the synchronised clock, three cycles behind the source pin
        // and with its pulse widths rounded to whole clock cycles
        case (psel)
            BCT_PSEL_SECOND: next_pinReg = halfSec;
            BCT_PSEL_SOURCE: next_pinReg = srcClk;
            default:         next_pinReg = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    // calendar starts on a Saturday, first of January, year 00, at midnight
    // alarm fields start at the earliest legal values

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable   <= 1'(`BCT_RST_CONTROL >> `BCT_CTL_ENABLE_BIT);
            wren     <= 1'b0;
            ptr      <= `BCT_RST_PTR;
            almPtr   <= `BCT_RST_PTR;
            psel     <= bct_psel_t'(`BCT_RST_PSEL);
            prescale <= 14'h0;
            halfSec  <= 1'b0;
            sec <= 8'h00; min <= 8'h00; hour <= 8'h00;
            weekday_digit <= 8'h06; day <= 8'h01; mon <= 8'h01; year <= 8'h00;
            aSec <= 8'h00; aMin <= 8'h00; aHour <= 8'h00;
            aWday <= 8'h00; aDay <= 8'h01; aMon <= 8'h01;
            rdData   <= 8'h00;
            pinReg   <= 1'b0;
        end else begin
            enable   <= next_enable;
            wren     <= next_wren;
            ptr      <= next_ptr;
            almPtr   <= next_almPtr;
            psel     <= next_psel;
            prescale <= next_prescale;
            halfSec  <= next_halfSec;
            sec <= next_sec; min <= next_min; hour <= next_hour;
            weekday_digit <= next_weekday_digit; day <= next_day; mon <= next_mon; year <= next_year;
            aSec <= next_aSec; aMin <= next_aMin; aHour <= next_aHour;
            aWday <= next_aWday; aDay <= next_aDay; aMon <= next_aMon;
            rdData   <= next_rdData;
            pinReg   <= next_pinReg;
        end
    end

    // crystal oscillator runs whenever it is the chosen source
    // the select is a static configuration bit, so this only follows it
    // once after reset in practice
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crystalOscEnable <= 1'b0;
        end else begin
            crystalOscEnable <= ~counterClockSelect;
        end
    end

    assign regRdData = rdData;
    assign pinOut    = pinReg;

endmodule

// [tb/bct_timekeeper_monitor.sv]
// port-level checks of the timekeeper value windows and crystal enable
`timescale 1ns/1ps
`include "bct_defines.svh"

module bct_timekeeper_monitor
    import bct_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic       writeUnlock,
    input wire logic       counterClockSelect,
    input wire logic       crystalClockPin,
    input wire logic       internalOscPin,
    input wire logic [7:0] regRdData,
    input wire logic       crystalOscEnable,
    input wire logic       pinOut
);
    logic     wren;
    logic     next_wren;
    bct_ptr_t ptr;
    bct_ptr_t next_ptr;
    logic     rdHigh;
    logic     rdLow;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////
    // shadow of write-enable and value pointer
    assign rdHigh = regRead && regAddr == `BCT_OFF_WIN_HIGH;
    assign rdLow  = regRead && regAddr == `BCT_OFF_WIN_LOW;

    always_comb begin
        next_wren = wren;
        next_ptr  = ptr;
        if (regWrite && regAddr == `BCT_OFF_CONTROL) begin
            next_wren = regWrData[`BCT_CTL_WREN_BIT] && (wren || writeUnlock);
            next_ptr  = regWrData[1:0];
        end else if ((rdHigh || (regWrite && regAddr == `BCT_OFF_WIN_HIGH && wren)) && ptr != 2'h0) begin
            next_ptr = ptr - 2'h1;
        end
    end

    // register the shadow
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wren <= 1'h0;
            ptr  <= `BCT_RST_PTR;
        end else begin
            wren <= next_wren;
            ptr  <= next_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // field layouts of window reads
    a_sec_layout: assert property (rdLow && ptr == 2'h0 |=>
        !regRdData[7] && regRdData[6:4] <= 3'h5 && regRdData[3:0] <= 4'h9) else $error("seconds out of range");
    a_min_layout: assert property (rdHigh && ptr == 2'h0 |=>
        !regRdData[7] && regRdData[6:4] <= 3'h5 && regRdData[3:0] <= 4'h9) else $error("minutes out of range");
    a_hour_layout: assert property (rdLow && ptr == 2'h1 |=>
        regRdData[7:6] == 2'h0 && regRdData[5:4] <= 2'h2 && regRdData[3:0] <= 4'h9) else $error("hours out of range");
    a_weekday_digit_range: assert property (rdHigh && ptr == 2'h1 |=> regRdData <= 8'h06)
        else $error("weekday out of range");
    a_day_layout: assert property (rdLow && ptr == 2'h2 |=>
        regRdData[7:6] == 2'h0 && regRdData[3:0] <= 4'h9 && regRdData != 8'h00) else $error("day out of range");
    a_month_layout: assert property (rdHigh && ptr == 2'h2 |=>
        regRdData[7:5] == 3'h0 && regRdData <= 8'h12 && regRdData != 8'h00) else $error("month out of range");
    a_year_digits: assert property (rdLow && ptr == 2'h3 |=>
        regRdData[7:4] <= 4'h9 && regRdData[3:0] <= 4'h9) else $error("year digit out of range");
    a_rsvd_zero: assert property (rdHigh && ptr == 2'h3 |=> regRdData == 8'h00)
        else $error("reserved slot not zero");
    a_xtal_enable: assert property (1'h1 |-> ##2 crystalOscEnable == !counterClockSelect)
        else $error("crystal enable does not follow select");

    // main scenarios
    c_rsvd_read: cover property (rdHigh && ptr == 2'h3);
    c_locked_write: cover property (regWrite && regAddr == `BCT_OFF_WIN_LOW && !wren);
    c_pin_toggle: cover property ($rose(pinOut));
endmodule

bind bct_timekeeper bct_timekeeper_monitor u_mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .writeUnlock(writeUnlock),
    .counterClockSelect(counterClockSelect), .crystalClockPin(crystalClockPin),
    .internalOscPin(internalOscPin), .regRdData(regRdData), .crystalOscEnable(crystalOscEnable), .pinOut(pinOut)
);

// [tb/test_bct_timekeeper.sv]
// self-checking bench of the timekeeper: access table, locks, rollover, pin, reset
`timescale 1ns/1ps
`include "bct_defines.svh"

module test_bct_timekeeper
    import bct_pkg::*;
;
    typedef struct packed {
        logic       wr;
        logic [3:0] a;
        bct_byte_t  d;
    } bct_row_t;

    logic       ref_clk;
    logic       rst_n;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrite;
    logic       regRead;
    logic       writeUnlock;
    logic       counterClockSelect;
    logic       crystalClockPin;
    logic       internalOscPin;
    logic [7:0] regRdData;
    logic       crystalOscEnable;
    logic       pinOut;
    int         failCount;
    int         numChecks;
    bct_byte_t  rdVal;
    logic       pinA;
    bct_byte_t  wrapVals [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    bct_byte_t  resetVals [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h06, 8'h00, 8'h00};
    bct_row_t   rows [30] = '{
        '{1'h1, 4'h0, 8'h23}, '{1'h1, 4'h2, 8'h99}, '{1'h0, 4'h1, 8'h00}, '{1'h1, 4'h2, 8'h31}, '{1'h1, 4'h1, 8'h12},
        '{1'h1, 4'h2, 8'h23}, '{1'h1, 4'h1, 8'h06}, '{1'h1, 4'h1, 8'h59}, '{1'h1, 4'h0, 8'h23}, '{1'h0, 4'h2, 8'h99},
        '{1'h0, 4'h1, 8'h00}, '{1'h0, 4'h2, 8'h31}, '{1'h0, 4'h1, 8'h12}, '{1'h0, 4'h2, 8'h23}, '{1'h0, 4'h1, 8'h06},
        '{1'h0, 4'h2, 8'h00}, '{1'h0, 4'h1, 8'h59}, '{1'h1, 4'h3, 8'h02}, '{1'h1, 4'h5, 8'h15}, '{1'h1, 4'h4, 8'h11},
        '{1'h1, 4'h3, 8'h02}, '{1'h0, 4'h5, 8'h15}, '{1'h0, 4'h4, 8'h11}, '{1'h0, 4'hF, 8'h00}, '{1'h1, 4'hF, 8'h77},
        '{1'h1, 4'h0, 8'h00}, '{1'h1, 4'h2, 8'h33}, '{1'h0, 4'h2, 8'h00}, '{1'h1, 4'h0, 8'h80}, '{1'h0, 4'h0, 8'h00}};

    bct_timekeeper u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .writeUnlock(writeUnlock),
        .counterClockSelect(counterClockSelect), .crystalClockPin(crystalClockPin),
        .internalOscPin(internalOscPin), .regRdData(regRdData), .crystalOscEnable(crystalOscEnable), .pinOut(pinOut)
    );

    ////////////////////////////////////////////////////////////////
    // clock and source pins, only the selected source runs
    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        crystalClockPin <= ~crystalClockPin & ~counterClockSelect;
        internalOscPin  <= ~internalOscPin & counterClockSelect;
    end

    ////////////////////////////////////////////////////////////////
    // compare, bus cycles and verdict
    task automatic chk(input bct_byte_t seen, input bct_byte_t want);
        numChecks++;
        if (seen !== want) begin
            failCount++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [3:0] a, input bct_byte_t d);
        @(posedge ref_clk);
        regWrite    <= 1'h1;
        regAddr     <= a;
        regWrData   <= d;
        writeUnlock <= (a == `BCT_OFF_CONTROL);
        @(posedge ref_clk);
        regWrite    <= 1'h0;
        writeUnlock <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output bct_byte_t d);
        @(posedge ref_clk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'h0;
        #1 d = regRdData;
    endtask

    task automatic readAll(input bct_byte_t e [8]);
        bct_byte_t v;
        for (int i = 0; i < 8; i++) begin
            rd(i[0] ? `BCT_OFF_WIN_HIGH : `BCT_OFF_WIN_LOW, v);
            chk(v, e[i]);
        end
    endtask

    task automatic giveVerdict();
        if (failCount == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ref_clk            = 1'h0;
        rst_n              = 1'h0;
        regAddr            = 4'h0;
        regWrData          = 8'h00;
        regWrite           = 1'h0;
        regRead            = 1'h0;
        writeUnlock        = 1'h0;
        counterClockSelect = 1'h0;
        crystalClockPin    = 1'h0;
        internalOscPin     = 1'h0;
        failCount          = 0;
        numChecks          = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, rdVal);
                chk(rdVal, rows[i].d);
            end
        end
        // one second from Saturday Dec 31 99 23:59:59
        wr(`BCT_OFF_CONTROL, 8'h20);
        wr(`BCT_OFF_CONTROL, 8'hA0);
        wr(`BCT_OFF_WIN_LOW, 8'h59);
        repeat (32800) @(posedge ref_clk);
        rd(`BCT_OFF_CONTROL, rdVal);
        chk(rdVal, 8'hA8);
        @(posedge ref_clk);
        #1 chk(regRdData, 8'h00);
        // half-second bit on the pin
        wr(`BCT_OFF_PIN_SEL, 8'h02);
        repeat (2) @(posedge ref_clk);
        #1 chk({7'h00, pinOut}, 8'h01);
        repeat (32690) @(posedge ref_clk);
        rd(`BCT_OFF_WIN_LOW, rdVal);
        chk(rdVal, 8'h59);
        repeat (100) @(posedge ref_clk);
        wr(`BCT_OFF_CONTROL, 8'hA3);
        readAll(wrapVals);
        // source clock routed to the pin
        wr(`BCT_OFF_PIN_SEL, 8'h04);
        repeat (4) @(posedge ref_clk);
        #1 pinA = pinOut;
        @(posedge ref_clk);
        #1 chk({7'h00, pinA ^ pinOut}, 8'h01);
        chk({7'h00, crystalOscEnable}, 8'h01);
        // reset in mid-run, selecting the internal oscillator as source in the same cycle
        @(posedge ref_clk);
        rst_n              <= 1'h0;
        counterClockSelect <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        wr(`BCT_OFF_CONTROL, 8'h03);
        rd(`BCT_OFF_CONTROL, rdVal);
        chk(rdVal, 8'h03);
        readAll(resetVals);
        // internal oscillator routed to the pin, crystal switched off
        wr(`BCT_OFF_PIN_SEL, 8'h04);
        repeat (4) @(posedge ref_clk);
        #1 pinA = pinOut;
        @(posedge ref_clk);
        #1 chk({7'h00, pinA ^ pinOut}, 8'h01);
        chk({7'h00, crystalOscEnable}, 8'h00);
        giveVerdict();
    end

    // hang guard, well past the expected run
    initial begin
        repeat (100000) @(posedge ref_clk);
        failCount++;
        giveVerdict();
    end
endmodule
